// file: common/udcs_pkg.sv
// Shared constants and types for the USB device control and status block
// Overview of operation
// - Bus reset optionally resets the CPU
// - Three-bit mode field steers pins, regulator
// - Host resume sets resume flag, wakes CPU
// - Leaving suspend clears suspend, then resume
// - Bus reset sets flag; clear needs unprotected
// - Wake command held until engine acknowledges
// - Suspend flag set; rising edge interrupts
// - Endpoint access flags, enabled interrupt, software clear
// - Two-bit field selects endpoint FIFO
// - Address bits 7..1, wake enable bit 0
// - Bit 0 enables remote wake-up
// - Stall bits cleared on reset, setup
// - NAK mask suppresses NAK interrupts
// - Error code set by engine, software clears
// - IN token indication read-only
// - OUT flag, cleared by software or setup
// - FIFO error flag; clear needs unprotected
// - Address adopted now or after IN read
// - Write-protect bit gates bus reset and FIFO error flag clears
package udcs_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_EPFLAG = 4'h1;
    localparam logic [3:0] OFS_CLKCTL = 4'h2;
    localparam logic [3:0] OFS_ADDR = 4'h3;
    localparam logic [3:0] OFS_STALL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    localparam logic [3:0] OFS_SYSCTL = 4'h6;
    localparam logic [3:0] OFS_EPIEN = 4'h7;
    // usb_control_status fields
    localparam int CTL_RESETCPU = 7;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_RESUME = 3;
    localparam int CTL_BUSRST = 2;
    localparam int CTL_WAKE = 1;
    localparam int CTL_SUSP = 0;
    localparam logic [7:0] CTL_RESET_VAL = 8'h80;
    // usb_clock_suspend_control fields
    localparam int CLK_REDUCE = 4;
    localparam int CLK_ENABLE = 3;
    localparam int CLK_SEL_LSB = 0;
    // engine_token_error_status fields
    localparam int ST_NAKMASK = 7;
    localparam int ST_ERR_LSB = 4;
    localparam int ST_IN = 3;
    localparam int ST_OUT = 2;
    localparam int ST_FERR = 1;
    localparam int ST_ADDRESS_UPDATE_TIMING = 0;
    localparam int SYS_PROTECT = 7;
    localparam logic [7:0] ADDR_RESET_VAL = 8'h00;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        UDCS_PIN_FLOAT = 2'b00,
        UDCS_PIN_OD = 2'b01,
        UDCS_PIN_USB = 2'b10
    } udcs_pin_t;
    typedef enum logic [1:0] {
        UDCS_WAKE_IDLE = 2'b00,
        UDCS_WAKE_HOLD = 2'b01
    } udcs_wake_t;
endpackage

// file: hw/udcs_sync.sv
// Two-flop synchroniser bank for engine event levels
`timescale 1ns/10ps
module udcs_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } udcs_sync_t;
    udcs_sync_t st_q, st_d;
    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign dout = st_q.s2;
endmodule

// file: hw/udcs_edge.sv
// Rising-edge pulse detector on synchronised levels
`timescale 1ns/10ps
module udcs_edge #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] lvl,
    output logic [WIDTH-1:0] rise
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } udcs_edge_t;
    udcs_edge_t st_q, st_d;
    always_comb begin
        st_d.prev = lvl;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign rise = lvl & ~st_q.prev;
endmodule

// file: hw/udcs_top.sv
// USB device control and status registers around the serial interface engine
`timescale 1ns/10ps
module udcs_top #(
    parameter int NUM_EP = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic eng_bus_reset,
    input wire logic eng_suspend,
    input wire logic eng_resume,
    input wire logic eng_left_suspend,
    input wire logic eng_setup,
    input wire logic eng_in_token,
    input wire logic eng_out_token,
    input wire logic eng_in_done,
    input wire logic eng_nak,
    input wire logic eng_err_evt,
    input wire logic [2:0] eng_err_code,
    input wire logic eng_fifo_err,
    input wire logic [NUM_EP-1:0] eng_ep_access,
    input wire logic eng_wake_ack,
    output logic cpu_reset_req,
    output logic usb_irq,
    output logic wake_cpu,
    output logic remote_wake_req,
    output logic [1:0] pin_mode,
    output logic regulator_output_en,
    output logic open_drain_pullup_en,
    output logic link_clock_enable,
    output logic suspend_current_reduce,
    output logic [1:0] fifo_select,
    output logic [6:0] device_address,
    output logic remote_wake_enable,
    output logic [NUM_EP-1:0] endpoint_stall_bits
);
    initial begin
        if (NUM_EP != 4) begin
            $error("udcs_top serves exactly four endpoints");
        end
    end

    localparam int NS = 9 + NUM_EP;

    typedef udcs_pkg::udcs_wake_t udcs_wake_fsm_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [NUM_EP-1:0] epf;
        logic [7:0] clkc;
        logic [7:0] addr;
        logic [NUM_EP-1:0] stall;
        logic [7:0] stat;
        logic protect;
        logic [NUM_EP-1:0] epien;
        logic [6:0] live_addr;
        logic [7:0] rdata;
        logic rst_cpu;
        logic irq;
        logic wake;
        logic rwake;
        udcs_wake_fsm_t wst;
        logic [1:0] pmode;
        logic reg_en;
        logic od_en;
    } udcs_state_t;

    udcs_state_t st_q, st_d;
    logic [NS-1:0] ev_raw, ev_lvl, ev_rise;
    logic [2:0] err_code_s;

    function automatic logic [1:0] udcs_mode_decode(input logic [2:0] m);
        logic [1:0] r;
        r = udcs_pkg::UDCS_PIN_FLOAT;
        if (m == 3'b001) begin
            r = udcs_pkg::UDCS_PIN_OD;
        end else if (m[2:1] == 2'b01) begin
            r = udcs_pkg::UDCS_PIN_USB;
        end
        return r;
    endfunction

    // Level inputs crossed in; pulses are edges of the synced levels
    assign ev_raw = {eng_ep_access, eng_wake_ack, eng_fifo_err, eng_err_evt, eng_nak,
                     eng_in_done, eng_out_token, eng_setup, eng_left_suspend,
                     eng_bus_reset};
    udcs_sync #(.WIDTH(NS)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(ev_raw),
        .dout(ev_lvl)
    );
    udcs_sync #(.WIDTH(3)) u_sync_err (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(eng_err_code),
        .dout(err_code_s)
    );
    udcs_edge #(.WIDTH(NS)) u_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lvl(ev_lvl),
        .rise(ev_rise)
    );

    logic [2:0] lvl_misc, lvl_misc_d;
    logic susp_rise, resume_rise;
    udcs_sync #(.WIDTH(3)) u_sync_misc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({eng_in_token, eng_resume, eng_suspend}),
        .dout(lvl_misc)
    );
    udcs_edge #(.WIDTH(3)) u_edge_misc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lvl(lvl_misc),
        .rise(lvl_misc_d)
    );
    assign susp_rise = lvl_misc_d[0];
    assign resume_rise = lvl_misc_d[1];

    logic bus_rst, left_susp, setup_ev, out_ev, in_done, nak_ev, err_ev, ferr_ev, wake_ack;
    logic [NUM_EP-1:0] ep_ev;
    assign bus_rst = ev_rise[0];
    assign left_susp = ev_rise[1];
    assign setup_ev = ev_rise[2];
    assign out_ev = ev_rise[3];
    assign in_done = ev_rise[4];
    assign nak_ev = ev_rise[5];
    assign err_ev = ev_rise[6];
    assign ferr_ev = ev_rise[7];
    assign wake_ack = ev_rise[8];
    assign ep_ev = ev_rise[NS-1:9];

    logic wr_ctrl, wr_epf, wr_clk, wr_addr, wr_stall, wr_stat, wr_sys, wr_ien;
    assign wr_ctrl = reg_wr && reg_addr == udcs_pkg::OFS_CTRL;
    assign wr_epf = reg_wr && reg_addr == udcs_pkg::OFS_EPFLAG;
    assign wr_clk = reg_wr && reg_addr == udcs_pkg::OFS_CLKCTL;
    assign wr_addr = reg_wr && reg_addr == udcs_pkg::OFS_ADDR;
    assign wr_stall = reg_wr && reg_addr == udcs_pkg::OFS_STALL;
    assign wr_stat = reg_wr && reg_addr == udcs_pkg::OFS_STATUS;
    assign wr_sys = reg_wr && reg_addr == udcs_pkg::OFS_SYSCTL;
    assign wr_ien = reg_wr && reg_addr == udcs_pkg::OFS_EPIEN;

    always_comb begin
        st_d = st_q;
        // Control register: writable mode, reset routing, wake command
        if (wr_ctrl) begin
            st_d.ctrl[7:4] = reg_wdata[7:4];
            st_d.ctrl[udcs_pkg::CTL_WAKE] = reg_wdata[udcs_pkg::CTL_WAKE];
            if (!st_q.protect && !reg_wdata[udcs_pkg::CTL_BUSRST]) begin
                st_d.ctrl[udcs_pkg::CTL_BUSRST] = 1'b0;
            end
        end
        if (bus_rst) begin
            st_d.ctrl[udcs_pkg::CTL_BUSRST] = 1'b1;
        end
        // Suspend and resume are engine-owned, read-only
        st_d.ctrl[udcs_pkg::CTL_SUSP] = st_q.ctrl[udcs_pkg::CTL_SUSP] | susp_rise;
        if (resume_rise) begin
            st_d.ctrl[udcs_pkg::CTL_RESUME] = 1'b1;
        end
        if (left_susp) begin
            st_d.ctrl[udcs_pkg::CTL_SUSP] = 1'b0;
        end
        // Resume drops one cycle after suspend, keeping the documented order
        if (!st_q.ctrl[udcs_pkg::CTL_SUSP] && st_q.ctrl[udcs_pkg::CTL_RESUME]
            && !resume_rise && !lvl_misc[1]) begin
            st_d.ctrl[udcs_pkg::CTL_RESUME] = 1'b0;
        end
        // Endpoint access flags; set wins over software clear
        if (wr_epf) begin
            st_d.epf = reg_wdata[NUM_EP-1:0];
        end
        st_d.epf = st_d.epf | ep_ev;
        if (wr_clk) begin
            st_d.clkc = {3'b000, reg_wdata[4:3], 1'b0, reg_wdata[1:0]};
        end
        if (wr_addr) begin
            st_d.addr = reg_wdata;
        end
        // Address adoption timing
        if (!st_q.stat[udcs_pkg::ST_ADDRESS_UPDATE_TIMING] && wr_addr) begin
            st_d.live_addr = reg_wdata[7:1];
        end else if (st_q.stat[udcs_pkg::ST_ADDRESS_UPDATE_TIMING] && in_done) begin
            st_d.live_addr = st_q.addr[7:1];
        end
        if (wr_stall) begin
            st_d.stall = reg_wdata[NUM_EP-1:0];
        end
        if (bus_rst || setup_ev) begin
            st_d.stall = '0;
        end
        // Status register
        if (wr_stat) begin
            st_d.stat[udcs_pkg::ST_NAKMASK] = reg_wdata[udcs_pkg::ST_NAKMASK];
            st_d.stat[6:4] = reg_wdata[6:4] & st_q.stat[6:4];
            st_d.stat[udcs_pkg::ST_ADDRESS_UPDATE_TIMING] = reg_wdata[udcs_pkg::ST_ADDRESS_UPDATE_TIMING];
            if (!st_q.protect && !reg_wdata[udcs_pkg::ST_FERR]) begin
                st_d.stat[udcs_pkg::ST_FERR] = 1'b0;
            end
            if (!reg_wdata[udcs_pkg::ST_OUT]) begin
                st_d.stat[udcs_pkg::ST_OUT] = 1'b0;
            end
        end
        if (err_ev) begin
            st_d.stat[6:4] = err_code_s;
        end
        if (ferr_ev) begin
            st_d.stat[udcs_pkg::ST_FERR] = 1'b1;
        end
        if (setup_ev) begin
            st_d.stat[udcs_pkg::ST_OUT] = 1'b0;
        end
        if (out_ev) begin
            st_d.stat[udcs_pkg::ST_OUT] = 1'b1;
        end
        st_d.stat[udcs_pkg::ST_IN] = lvl_misc[2];
        if (wr_sys) begin
            st_d.protect = reg_wdata[udcs_pkg::SYS_PROTECT];
        end
        if (wr_ien) begin
            st_d.epien = reg_wdata[NUM_EP-1:0];
        end
        // Remote wake: hold request until engine acknowledges
        unique case (st_q.wst)
            udcs_pkg::UDCS_WAKE_IDLE: begin
                if (st_q.ctrl[udcs_pkg::CTL_WAKE] && st_q.addr[0]) begin
                    st_d.wst = udcs_pkg::UDCS_WAKE_HOLD;
                end
            end
            udcs_pkg::UDCS_WAKE_HOLD: begin
                if (wake_ack) begin
                    st_d.wst = udcs_pkg::UDCS_WAKE_IDLE;
                    st_d.ctrl[udcs_pkg::CTL_WAKE] = 1'b0;
                end
            end
            default: begin
                st_d.wst = udcs_pkg::UDCS_WAKE_IDLE;
            end
        endcase
        st_d.rwake = st_d.wst == udcs_pkg::UDCS_WAKE_HOLD;
        // Outputs registered
        st_d.rst_cpu = bus_rst && st_q.ctrl[udcs_pkg::CTL_RESETCPU];
        st_d.irq = susp_rise || resume_rise || bus_rst
            || |(ep_ev & st_q.epien)
            || (nak_ev && !st_q.stat[udcs_pkg::ST_NAKMASK] && |st_q.epien);
        st_d.wake = resume_rise;
        st_d.pmode = udcs_mode_decode(st_q.ctrl[6:4]);
        st_d.reg_en = st_d.pmode == udcs_pkg::UDCS_PIN_USB;
        st_d.od_en = st_d.pmode == udcs_pkg::UDCS_PIN_OD;
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                udcs_pkg::OFS_CTRL: st_d.rdata = st_q.ctrl;
                udcs_pkg::OFS_EPFLAG: st_d.rdata = {4'h0, st_q.epf};
                udcs_pkg::OFS_CLKCTL: st_d.rdata = st_q.clkc;
                udcs_pkg::OFS_ADDR: st_d.rdata = st_q.addr;
                udcs_pkg::OFS_STALL: st_d.rdata = {4'h0, st_q.stall};
                udcs_pkg::OFS_STATUS: st_d.rdata = st_q.stat;
                udcs_pkg::OFS_SYSCTL: st_d.rdata = {st_q.protect, 7'h00};
                udcs_pkg::OFS_EPIEN: st_d.rdata = {4'h0, st_q.epien};
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.ctrl <= udcs_pkg::CTL_RESET_VAL;
            st_q.addr <= udcs_pkg::ADDR_RESET_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign cpu_reset_req = st_q.rst_cpu;
    assign usb_irq = st_q.irq;
    assign wake_cpu = st_q.wake;
    assign remote_wake_req = st_q.rwake;
    assign pin_mode = st_q.pmode;
    assign regulator_output_en = st_q.reg_en;
    assign open_drain_pullup_en = st_q.od_en;
    assign link_clock_enable = st_q.clkc[udcs_pkg::CLK_ENABLE];
    assign suspend_current_reduce = st_q.clkc[udcs_pkg::CLK_REDUCE];
    assign fifo_select = st_q.clkc[1:0];
    assign device_address = st_q.live_addr;
    assign remote_wake_enable = st_q.addr[0];
    assign endpoint_stall_bits = st_q.stall;
endmodule

// file: verification/udcs_top_sva.sv
// Port assertions for the USB control and status block
`timescale 1ns/10ps
module udcs_top_chk #(
    parameter int NUM_EP = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic eng_bus_reset,
    input wire logic eng_suspend,
    input wire logic eng_resume,
    input wire logic eng_setup,
    input wire logic cpu_reset_req,
    input wire logic usb_irq,
    input wire logic wake_cpu,
    input wire logic remote_wake_req,
    input wire logic [1:0] pin_mode,
    input wire logic open_drain_pullup_en,
    input wire logic remote_wake_enable,
    input wire logic [NUM_EP-1:0] endpoint_stall_bits
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Synchroniser and edge detect put event outputs a few cycles late
    sequence s_late_irq;
        ##[2:6] usb_irq;
    endsequence
    sequence s_wake_start;
        $rose(remote_wake_req);
    endsequence
    sequence s_od_write;
        reg_wr && reg_addr == udcs_pkg::OFS_CTRL && reg_wdata[6:4] == 3'b001;
    endsequence
    AST_CPURST: assert property (cpu_reset_req |->
        $past(eng_bus_reset, 3) || $past(eng_bus_reset, 4) || $past(eng_bus_reset, 5))
        else $error("cpu reset without bus reset");
    AST_RESWAKE: assert property ($rose(eng_resume) |-> ##[2:6] wake_cpu)
        else $error("no wake pulse after resume");
    AST_SUSIRQ: assert property ($rose(eng_suspend) |-> s_late_irq)
        else $error("no irq after suspend");
    AST_RSTIRQ: assert property ($rose(eng_bus_reset) |-> s_late_irq)
        else $error("no irq after bus reset");
    AST_STLCLR: assert property ($rose(eng_setup) || $rose(eng_bus_reset) |->
        ##[2:6] endpoint_stall_bits == '0)
        else $error("stall bits not cleared");
    AST_ODPIN: assert property (s_od_write |-> ##[1:3] pin_mode == 2'b01 && open_drain_pullup_en)
        else $error("open drain mode not taken");
    AST_REMOTE_WAKE_ENABLE: assert property (s_wake_start |-> remote_wake_enable)
        else $error("wake request while disabled");
    AST_WKHOLD: assert property (s_wake_start |=> remote_wake_req [*2])
        else $error("wake request dropped early");
endmodule
bind udcs_top udcs_top_chk #(.NUM_EP(NUM_EP)) i_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .eng_bus_reset, .eng_suspend, .eng_resume, .eng_setup, .cpu_reset_req, .usb_irq,
    .wake_cpu, .remote_wake_req, .pin_mode, .open_drain_pullup_en, .remote_wake_enable,
    .endpoint_stall_bits);

// file: verification/udcs_eng_model.sv
// Engine-side model: event levels and wake acknowledge
`timescale 1ns/10ps
module udcs_eng_model (
    input wire logic ref_clk,
    input wire logic remote_wake_req,
    output logic [14:0] lv,
    output logic eng_wake_ack
);
    // Long hold so each level survives the two-flop synchroniser
    int hold = 6;
    // Slow answer, so the block must keep its request standing
    int ack_delay = 12;
    // Bus reset, suspend, resume, setup, tokens, errors, endpoint hits
    task automatic evt(input int n);
        lv[n] <= 1'b1;
        repeat (hold) @(posedge ref_clk);
        lv[n] <= 1'b0;
        repeat (hold) @(posedge ref_clk);
    endtask
    task automatic lvl(input int n, input logic v);
        lv[n] <= v;
        repeat (8) @(posedge ref_clk);
    endtask
    initial begin
        lv = '0;
        eng_wake_ack = 1'b0;
        forever begin
            while (remote_wake_req !== 1'b1) @(posedge ref_clk);
            repeat (ack_delay) @(posedge ref_clk);
            eng_wake_ack <= 1'b1;
            while (remote_wake_req !== 1'b0) @(posedge ref_clk);
            eng_wake_ack <= 1'b0;
        end
    end
endmodule

// file: verification/udcs_top_test.sv
// Directed bench for the USB control and status block
`timescale 1ns/10ps
module udcs_top_test;
    localparam logic [3:0] CTL = udcs_pkg::OFS_CTRL;
    localparam logic [3:0] ST = udcs_pkg::OFS_STATUS;
    localparam logic [3:0] ADR = udcs_pkg::OFS_ADDR;
    localparam logic [3:0] SYS = udcs_pkg::OFS_SYSCTL;
    localparam logic [3:0] ENDPOINT_STALL = udcs_pkg::OFS_STALL;
    logic ref_clk, rst_n, reg_wr, reg_rd, eng_wake_ack, cpu_reset_req, usb_irq, wake_cpu;
    logic remote_wake_req, regulator_output_en, open_drain_pullup_en, link_clock_enable;
    logic suspend_current_reduce, remote_wake_enable;
    logic [3:0] reg_addr, endpoint_stall_bits;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] pin_mode, fifo_select;
    logic [6:0] device_address;
    logic [14:0] lv;
    logic [2:0] eng_err_code;
    int fails = 0, total_checks = 0, irqs = 0, cpurs = 0, wakes = 0, cycles = 0, b, c;
    udcs_eng_model m (.ref_clk, .remote_wake_req, .lv, .eng_wake_ack);
    udcs_top i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .eng_bus_reset(lv[0]), .eng_suspend(lv[1]), .eng_resume(lv[2]),
        .eng_left_suspend(lv[3]), .eng_setup(lv[4]), .eng_in_token(lv[5]),
        .eng_out_token(lv[6]), .eng_in_done(lv[7]), .eng_nak(lv[8]), .eng_err_evt(lv[9]),
        .eng_err_code, .eng_fifo_err(lv[10]), .eng_ep_access(lv[14:11]), .eng_wake_ack,
        .cpu_reset_req, .usb_irq, .wake_cpu, .remote_wake_req, .pin_mode, .regulator_output_en,
        .open_drain_pullup_en, .link_clock_enable, .suspend_current_reduce, .fifo_select,
        .device_address, .remote_wake_enable, .endpoint_stall_bits);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        irqs <= irqs + int'(usb_irq === 1'b1);
        cpurs <= cpurs + int'(cpu_reset_req === 1'b1);
        wakes <= wakes + int'(wake_cpu === 1'b1);
        // Whole run needs about 460 cycles
        if (cycles == 6000) begin
            $display("timeout");
            fails++;
            results();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(n, e, reg_rdata);
        @(posedge ref_clk);
    endtask
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        eng_err_code = 3'h0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd("ctl reset", CTL, 8'h80);
        rd("adr reset", ADR, 8'h00);
        b = cpurs;
        m.evt(0);
        chk("cpu reset on", 8'(b + 1), 8'(cpurs));
        rd("bus reset flag", CTL, 8'h84);
        wr(SYS, 8'h80);
        wr(CTL, 8'h80);
        rd("protected clear", CTL, 8'h84);
        wr(SYS, 8'h00);
        wr(CTL, 8'h00);
        rd("bus reset clear", CTL, 8'h00);
        b = cpurs;
        m.evt(0);
        chk("cpu reset off", 8'(b), 8'(cpurs));
        $display("bus reset test done");
        for (int i = 0; i < 8; i++) begin
            wr(CTL, 8'(i << 4));
            @(negedge ref_clk);
            chk("pin mode", (i == 1) ? 8'h01 : (i == 2 || i == 3) ? 8'h02 : 8'h00, 8'(pin_mode));
            chk("regulator", (i == 2 || i == 3) ? 8'h01 : 8'h00, 8'(regulator_output_en));
            chk("od pullup", (i == 1) ? 8'h01 : 8'h00, 8'(open_drain_pullup_en));
            @(posedge ref_clk);
        end
        wr(CTL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(udcs_pkg::OFS_CLKCTL, 8'(8 + i));
            @(negedge ref_clk);
            chk("fifo select", 8'(i), 8'(fifo_select));
            chk("link clock", 8'h01, 8'(link_clock_enable));
            chk("current reduce", 8'h00, 8'(suspend_current_reduce));
            @(posedge ref_clk);
        end
        $display("mode test done");
        c = irqs;
        m.evt(1);
        rd("suspend", CTL, 8'h01);
        chk("suspend irq", 8'(c + 1), 8'(irqs));
        b = wakes;
        m.evt(2);
        rd("resume", CTL, 8'h09);
        chk("resume wake", 8'(b + 1), 8'(wakes));
        m.evt(3);
        rd("left suspend", CTL, 8'h00);
        wr(ENDPOINT_STALL, 8'h0F);
        rd("stall set", ENDPOINT_STALL, 8'h0F);
        m.evt(4);
        rd("stall setup", ENDPOINT_STALL, 8'h00);
        wr(ENDPOINT_STALL, 8'h05);
        m.evt(0);
        rd("stall bus reset", ENDPOINT_STALL, 8'h00);
        wr(CTL, 8'h00);
        $display("suspend and stall test done");
        wr(udcs_pkg::OFS_EPIEN, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            c = irqs;
            m.evt(11 + i);
            rd("ep flag", udcs_pkg::OFS_EPFLAG, 8'(1 << i));
            chk("ep irq", 8'(c + 1), 8'(irqs));
            wr(udcs_pkg::OFS_EPFLAG, 8'h00);
        end
        wr(ST, 8'h80);
        c = irqs;
        m.evt(8);
        chk("nak masked", 8'(c), 8'(irqs));
        wr(ST, 8'h00);
        m.evt(8);
        chk("nak open", 8'(c + 1), 8'(irqs));
        for (int i = 4; i < 8; i++) begin
            eng_err_code <= 3'(i);
            m.evt(9);
            rd("error code", ST, 8'(i << 4));
            wr(ST, 8'h00);
        end
        m.evt(10);
        wr(SYS, 8'h80);
        wr(ST, 8'h00);
        rd("fifo err kept", ST, 8'h02);
        wr(SYS, 8'h00);
        wr(ST, 8'h00);
        rd("fifo err clear", ST, 8'h00);
        m.evt(6);
        rd("out token", ST, 8'h04);
        m.evt(4);
        rd("out setup", ST, 8'h00);
        m.lvl(5, 1'b1);
        rd("in token", ST, 8'h08);
        m.lvl(5, 1'b0);
        rd("no in token", ST, 8'h00);
        $display("status test done");
        wr(ADR, 8'h2B);
        @(negedge ref_clk);
        chk("live address", 8'h15, 8'(device_address));
        chk("wake enable", 8'h01, 8'(remote_wake_enable));
        @(posedge ref_clk);
        wr(ST, 8'h01);
        wr(ADR, 8'h55);
        @(negedge ref_clk);
        chk("held address", 8'h15, 8'(device_address));
        @(posedge ref_clk);
        m.evt(7);
        @(negedge ref_clk);
        chk("adopted address", 8'h2A, 8'(device_address));
        @(posedge ref_clk);
        wr(ST, 8'h00);
        wr(CTL, 8'h02);
        for (int k = 0; k < 8 && remote_wake_req !== 1'b1; k++) @(negedge ref_clk);
        chk("wake req", 8'h01, 8'(remote_wake_req));
        for (int k = 0; k < 40 && remote_wake_req !== 1'b0; k++) @(negedge ref_clk);
        chk("wake acked", 8'h00, 8'(remote_wake_req));
        @(posedge ref_clk);
        wr(CTL, 8'h00);
        wr(ADR, 8'h54);
        wr(CTL, 8'h02);
        repeat (8) @(negedge ref_clk);
        chk("wake disabled", 8'h00, 8'(remote_wake_req));
        $display("address and wake test done");
        results();
    end
endmodule
